// File: design/adc_control.sv
// How it works
// RQ1: converter runs only while the enable bit is one, off otherwise.
// RQ2: with halt-in-idle set, converter stops once the device is idle.
// RQ3: order bit zero gives scatter address from input index and buffer size.
// RQ4: twelve-bit bit picks 12-bit single channel, else 10-bit four channel.
// RQ5: 10-bit format 00 gives right-justified unsigned result, upper bits zero.
// RQ6: 10-bit format 10 gives left-justified unsigned result, low bits zero.
// RQ7: 10-bit format 01 gives signed integer with inverted MSB as sign.
// RQ8: 12-bit format 11 signed fractional; 10 and 00 left/right unsigned.
// RQ9: software must not clear done while auto sampling is on.
// RQ10: unused bits read zero; sample and done flags settable by hardware too.
`timescale 1ns/1ps
`default_nettype none
module adc_control
  import adc_ctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_req,
  input  wire logic        sample_begin,
  input  wire logic        sample_end,
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_raw,
  input  wire logic [4:0]  input_index,
  output logic             converter_run,
  output logic             twelve_bit_mode,
  output logic             dma_order_mode,
  output logic [2:0]       conversion_trigger_source,
  output logic             trigger_group_select,
  output logic             simultaneous_sampling,
  output logic             auto_sampling,
  output logic             sample_active,
  output logic [15:0]      result_word,
  output logic             result_valid,
  output logic [15:0]      dma_addr,
  output logic             irq
);
  logic [15:0]         ctrl;
  logic [STATUS_W-1:0] status;
  logic [STATUS_W-1:0] mask;
  logic [BUFSZ_W-1:0]  bufsz;
  logic [7:0]          conv_count;
  logic                idle_sync;
  logic                halted;

  result_if rif ();

  // idle request comes from the power controller, another domain
  bit_sync u_idle_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (idle_req),
    .dout    (idle_sync)
  );

  // result layout according to width and format
  assign rif.raw    = conv_raw;
  assign rif.twelve = ctrl[B12_BIT];
  assign rif.fmt    = ctrl[FMT_LO+1:FMT_LO];

  result_shaper u_shaper (
    .rif (rif)
  );

  // bus decode
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable & pready;
  wire wr_now     = access_ph & pwrite;
  wire hit_ctrl   = (paddr == CTRL_OFS);
  wire hit_status = (paddr == STATUS_OFS);
  wire hit_mask   = (paddr == MASK_OFS);
  wire hit_result = (paddr == RESULT_OFS);
  wire hit_bufsz  = (paddr == BUFSZ_OFS);
  wire mapped     = hit_ctrl | hit_status | hit_mask | hit_result | hit_bufsz;
  wire wr_ctrl    = wr_now & hit_ctrl;
  wire wr_status  = wr_now & hit_status & pstrb[0];
  wire wr_mask    = wr_now & hit_mask & pstrb[0];
  wire wr_bufsz   = wr_now & hit_bufsz & pstrb[0];

  // byte-lane write mask over the control word
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wmask     = wr_ctrl ? (CTRL_WMASK & lane_mask) : 16'h0000;

  // converter state
  wire halt_now   = ctrl[HALT_BIT] & idle_sync;       // [RQ2]
  wire run_now    = ctrl[ON_BIT] & ~halt_now;          // [RQ1]
  wire take_conv  = conv_valid & run_now;
  wire sample_active_set   = sample_begin & run_now;
  wire idle_event = halt_now & ~halted & ctrl[ON_BIT];

  // software writes to sample and done
  wire sw_sample_active_wr  = wr_ctrl & pstrb[0];
  wire sw_done_clr = wr_ctrl & pstrb[0] & ~pwdata[DONE_BIT];

  // sample flag: hardware set and clear, software writable
  wire next_sample_active = sample_active_set ? 1'b1 :
                   sample_end ? 1'b0 :
                   sw_sample_active_wr ? pwdata[SAMPLE_ACTIVE_BIT] : ctrl[SAMPLE_ACTIVE_BIT];

  // done flag: set by conversion wins over any clear
  wire next_done = take_conv ? 1'b1 :
                   (sample_active_set | sw_done_clr) ? 1'b0 : ctrl[DONE_BIT];

  // plain control bits, unimplemented bits stay zero
  wire [15:0] plain_ctrl = (ctrl & ~wmask) | (pwdata[15:0] & wmask);
  wire [15:0] next_ctrl  = {plain_ctrl[15:2], next_sample_active, next_done};

  // status events, set wins over the write-one clear
  wire [STATUS_W-1:0] ev;
  assign ev[ST_DONE]      = take_conv;
  assign ev[ST_IDLE_HALT] = idle_event;
  wire [STATUS_W-1:0] clr = wr_status ? pwdata[STATUS_W-1:0] : '0;
  wire [STATUS_W-1:0] next_status = (status & ~clr) | ev;

  // dma address: scatter slot or running conversion order
  wire [15:0] slot_mask = ~(16'hFFFF << bufsz);
  wire [15:0] base_addr = {11'h000, input_index} << bufsz;
  wire [15:0] scat_addr = base_addr | ({8'h00, conv_count} & slot_mask);
  wire [15:0] ord_addr  = {8'h00, conv_count};
  wire [15:0] next_addr = ctrl[DMA_BIT] ? ord_addr : scat_addr;  // [RQ3]

  // read mux, unmapped addresses read zero
  wire [31:0] rd_ctrl   = {16'h0000, ctrl};                     // [RQ10]
  wire [31:0] rd_status = {{(32-STATUS_W){1'b0}}, status};
  wire [31:0] rd_mask   = {{(32-STATUS_W){1'b0}}, mask};
  wire [31:0] rd_result = {16'h0000, result_word};
  wire [31:0] rd_bufsz  = {{(32-BUFSZ_W){1'b0}}, bufsz};
  wire [31:0] next_rdata = hit_ctrl   ? rd_ctrl   :
                           hit_status ? rd_status :
                           hit_mask   ? rd_mask   :
                           hit_result ? rd_result :
                           hit_bufsz  ? rd_bufsz  : 32'h0000_0000;

  // bus answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata  <= setup_ph ? next_rdata : prdata;
    end
  end

  // control word with hardware-set sample and done flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;                               // [RQ10]
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RESET;
      mask   <= MASK_RESET;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= wr_mask ? pwdata[STATUS_W-1:0] : mask;
      irq    <= |(next_status & mask);
    end
  end

  // buffer size and halt tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bufsz  <= BUFSZ_RESET;
      halted <= 1'b0;
    end else begin
      bufsz  <= wr_bufsz ? pwdata[BUFSZ_W-1:0] : bufsz;
      halted <= halt_now;
    end
  end

  // run output follows enable and idle halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_run <= 1'b0;
    end else begin
      converter_run <= run_now;                        // [RQ1] [RQ2]
    end
  end

  // conversion counter, cleared while the enable bit is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_count <= COUNT_RESET;
    end else if (!ctrl[ON_BIT]) begin
      conv_count <= COUNT_RESET;                       // [RQ1]
    end else if (take_conv) begin
      conv_count <= conv_count + 8'h01;
    end
  end

  // result and its dma address, captured per conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_word  <= WORD_RESET;
      result_valid <= 1'b0;
      dma_addr     <= WORD_RESET;
    end else begin
      result_valid <= take_conv;
      if (take_conv) begin
        result_word <= rif.word;                       // [RQ5] [RQ6] [RQ7] [RQ8]
        dma_addr    <= next_addr;                      // [RQ3]
      end
    end
  end

  // configuration outputs straight from the control word
  assign twelve_bit_mode           = ctrl[B12_BIT];    // [RQ4]
  assign dma_order_mode            = ctrl[DMA_BIT];
  assign conversion_trigger_source = ctrl[TRIG_LO+2:TRIG_LO];
  assign trigger_group_select      = ctrl[GROUP_BIT];
  assign simultaneous_sampling     = ctrl[SIM_BIT];
  assign auto_sampling             = ctrl[AUTO_SAMPLING_BIT];
  assign sample_active             = ctrl[SAMPLE_ACTIVE_BIT];
endmodule // adc_control
`default_nettype wire

// File: design/adc_ctl_pkg.sv
package adc_ctl_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] MASK_OFS   = 12'h008;
  localparam logic [11:0] RESULT_OFS = 12'h00C;
  localparam logic [11:0] BUFSZ_OFS  = 12'h010;
  // control word field positions
  localparam int ON_BIT    = 15;
  localparam int HALT_BIT  = 13;
  localparam int DMA_BIT   = 12;
  localparam int B12_BIT   = 10;
  localparam int FMT_LO    = 8;
  localparam int TRIG_LO   = 5;
  localparam int GROUP_BIT = 4;
  localparam int SIM_BIT   = 3;
  localparam int AUTO_SAMPLING_BIT  = 2;
  localparam int SAMPLE_ACTIVE_BIT  = 1;
  localparam int DONE_BIT  = 0;
  // writable plain bits; sample and done handled apart
  localparam logic [15:0] CTRL_WMASK = 16'hB7FC;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // status / mask layout
  localparam int          STATUS_W     = 2;
  localparam int          ST_DONE      = 0;
  localparam int          ST_IDLE_HALT = 1;
  localparam logic [1:0]  STATUS_RESET = 2'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h0;
  // dma buffer size, log2 of words per input
  localparam int          BUFSZ_W     = 3;
  localparam logic [2:0]  BUFSZ_RESET = 3'h0;
  localparam logic [7:0]  COUNT_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  // output format codes
  typedef enum logic [1:0] {
    FMT_INT   = 2'b00,
    FMT_SINT  = 2'b01,
    FMT_FRAC  = 2'b10,
    FMT_SFRAC = 2'b11
  } format_t;
endpackage

// File: design/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  logic stage;

  // two flops, first one read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 1'b0;
      dout  <= 1'b0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule // bit_sync
`default_nettype wire

// File: design/result_if.sv
`timescale 1ns/1ps
`default_nettype none
interface result_if;
  logic [11:0] raw;
  logic        twelve;
  logic [1:0]  fmt;
  logic [15:0] word;
  modport producer (output raw, output twelve, output fmt, input word);
  modport shaper   (input raw, input twelve, input fmt, output word);
endinterface : result_if
`default_nettype wire

// File: design/result_shaper.sv
`timescale 1ns/1ps
`default_nettype none
module result_shaper
  import adc_ctl_pkg::*;
(
  result_if.shaper rif
);
  logic [9:0]  d10;
  logic [11:0] d12;
  logic [15:0] w10;
  logic [15:0] w12;

  assign d10 = rif.raw[9:0];
  assign d12 = rif.raw;

  // ten-bit layouts
  always_comb begin
    unique case (format_t'(rif.fmt))
      FMT_INT:   w10 = {6'h00, d10};                 // [RQ5]
      FMT_FRAC:  w10 = {d10, 6'h00};                 // [RQ6]
      FMT_SINT:  w10 = {{7{~d10[9]}}, d10[8:0]};     // [RQ7]
      FMT_SFRAC: w10 = {~d10[9], d10[8:0], 6'h00};
    endcase
  end

  // twelve-bit layouts
  always_comb begin
    unique case (format_t'(rif.fmt))
      FMT_INT:   w12 = {4'h0, d12};                  // [RQ8]
      FMT_FRAC:  w12 = {d12, 4'h0};                  // [RQ8]
      FMT_SINT:  w12 = {{5{~d12[11]}}, d12[10:0]};
      FMT_SFRAC: w12 = {~d12[11], d12[10:0], 4'h0};  // [RQ8]
    endcase
  end

  assign rif.word = rif.twelve ? w12 : w10;          // [RQ4]
endmodule // result_shaper
`default_nettype wire

// File: tb/adc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_bench
  import adc_ctl_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, idle_req, conv_valid;
  logic        run, twelve, order, rvalid, irq, sl;
  logic [11:0] paddr, conv_raw;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  input_index;
  logic [15:0] rword, daddr;
  logic        sample_active_go, sample_active_stop, grp, simul, autos, sact;
  logic [2:0]  trig;
  int          err_total, total_checks;
  adc_control DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_req(idle_req), .sample_begin(sample_active_go), .sample_end(sample_active_stop), .conv_valid(conv_valid),
    .conv_raw(conv_raw), .input_index(input_index), .converter_run(run), .twelve_bit_mode(twelve),
    .dma_order_mode(order), .conversion_trigger_source(trig), .trigger_group_select(grp),
    .simultaneous_sampling(simul), .auto_sampling(autos), .sample_active(sact), .result_word(rword),
    .result_valid(rvalid), .dma_addr(daddr), .irq(irq));
  always #2.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // one conversion pulse; returns in the answer cycle
  task automatic conv(input logic [11:0] r, input logic [4:0] ix);
    @(posedge pclk);
    conv_valid <= 1'b1; conv_raw <= r; input_index <= ix;
    @(posedge pclk);
    conv_valid <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] shape(input logic [2:0] m, input logic [11:0] r);
    case (m)
      3'h0: return {6'h00, r[9:0]};
      3'h2: return {r[9:0], 6'h00};
      3'h1: return {{7{~r[9]}}, r[8:0]};
      3'h3: return {~r[9], r[8:0], 6'h00};
      3'h4: return {4'h0, r};
      3'h6: return {r, 4'h0};
      3'h5: return {{5{~r[11]}}, r[10:0]};
      default: return {~r[11], r[10:0], 4'h0};
    endcase
  endfunction
  task automatic t_regs;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'hFFFF_FFFF); // done written as one, never cleared with auto sampling on
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_B7FE);
    chk({run, twelve, order}, 3'h7);
    chk({trig, grp, simul, autos, sact}, 7'h7F);
    apb(1'b0, 12'h020, 32'h0);
    chk(sl, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0000_0001); // auto sampling off before any done clear
  endtask
  task automatic t_fmt;
    for (int m = 0; m < 16; m++) begin
      apb(1'b1, CTRL_OFS, 32'h8000 | ((m & 4) << 8) | ((m & 3) << 8));
      conv(m[3] ? 12'hA53 : 12'h5AC, 5'h00);
      chk(rvalid, 1'b1);
      chk(rword, shape(m[2:0], m[3] ? 12'hA53 : 12'h5AC));
    end
  endtask
  task automatic t_irq;
    apb(1'b1, MASK_OFS, 32'h1);
    conv(12'h123, 5'h00);
    chk(irq, 1'b1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, STATUS_OFS, 32'h1);
    #1;
    chk(irq, 1'b0);
    apb(1'b1, MASK_OFS, 32'h0);
    conv(12'h123, 5'h00);
    chk(irq, 1'b0);
    apb(1'b1, STATUS_OFS, 32'h3);
  endtask
  task automatic t_dma;
    apb(1'b1, CTRL_OFS, 32'h0);
    conv(12'h3FF, 5'h00);
    chk({rvalid, run}, 2'h0);
    apb(1'b1, BUFSZ_OFS, 32'h2);
    apb(1'b1, CTRL_OFS, 32'h8000);
    conv(12'h001, 5'h05);
    chk(daddr, 16'h0014);
    conv(12'h002, 5'h05);
    chk(daddr, 16'h0015);
    apb(1'b1, CTRL_OFS, 32'h9000);
    conv(12'h003, 5'h05);
    chk(daddr, 16'h0002);
  endtask
  // hardware sets sample, clears done, then ends sampling
  task automatic t_sample_active;
    apb(1'b1, CTRL_OFS, 32'h8000);
    conv(12'h001, 5'h00);
    @(posedge pclk);
    sample_active_go <= 1'b1;
    @(posedge pclk);
    sample_active_go <= 1'b0;
    #1;
    chk(sact, 1'b1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd[1:0], 2'h2);
    @(posedge pclk);
    sample_active_stop <= 1'b1;
    @(posedge pclk);
    sample_active_stop <= 1'b0;
    #1;
    chk(sact, 1'b0);
  endtask
  task automatic t_halt;
    apb(1'b1, CTRL_OFS, 32'hA000);
    idle_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(run, 1'b0);
    conv(12'h0AA, 5'h00);
    chk(rvalid, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd[1], 1'b1);
    apb(1'b1, CTRL_OFS, 32'h8000);
    repeat (3) @(posedge pclk);
    #1;
    chk(run, 1'b1);
    @(posedge pclk);
    idle_req <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #50000;
    err_total++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, idle_req, conv_valid, sample_active_go, sample_active_stop} = 8'h00;
    {paddr, conv_raw, pwdata, input_index} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fmt();
    t_irq();
    t_dma();
    t_sample_active();
    t_halt();
    test_done();
  end
endmodule // adc_control_bench
`default_nettype wire

// File: tb/adc_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_checker
  import adc_ctl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        conv_valid,
  input wire logic [11:0] conv_raw,
  input wire logic        converter_run,
  input wire logic        twelve_bit_mode,
  input wire logic        dma_order_mode,
  input wire logic [15:0] result_word,
  input wire logic        result_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the format field, taken from control writes
  logic [1:0] fmt_q;
  wire logic  wr_ctrl = psel & penable & pready & pwrite & (paddr == CTRL_OFS) & pstrb[1];
  wire logic  rd_ctrl = psel & penable & pready & !pwrite & (paddr == CTRL_OFS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fmt_q <= 2'h0;
    else if (wr_ctrl) fmt_q <= pwdata[9:8];
  end
  int10_fmt_a: assert property (result_valid && !twelve_bit_mode && fmt_q == 2'h0
    |-> result_word == {6'h00, $past(conv_raw[9:0])}) else $error("int10 word wrong");
  frac10_fmt_a: assert property (result_valid && !twelve_bit_mode && fmt_q == 2'h2
    |-> result_word == {$past(conv_raw[9:0]), 6'h00}) else $error("frac10 word wrong");
  sint10_fmt_a: assert property (result_valid && !twelve_bit_mode && fmt_q == 2'h1
    |-> result_word == {{7{~$past(conv_raw[9])}}, $past(conv_raw[8:0])}) else $error("sint10 word wrong");
  sfrac12_fmt_a: assert property (result_valid && twelve_bit_mode && fmt_q == 2'h3
    |-> result_word == {~$past(conv_raw[11]), $past(conv_raw[10:0]), 4'h0}) else $error("sfrac12 word wrong");
  result_cause_a: assert property (result_valid |-> $past(conv_valid)) else $error("result without sample");
  take_when_on_a: assert property (conv_valid && converter_run |=> result_valid) else $error("sample lost");
  run_gate_a: assert property (result_valid |-> converter_run) else $error("result while stopped");
  mode_follow_a: assert property (wr_ctrl |=> twelve_bit_mode == $past(pwdata[10])) else $error("mode bit");
  order_follow_a: assert property (wr_ctrl |=> dma_order_mode == $past(pwdata[12])) else $error("order bit");
  hole_zero_a: assert property (rd_ctrl |-> prdata[31:16] == 16'h0000 && !prdata[14] && !prdata[11])
    else $error("unused bits set");
endmodule // adc_control_checker
bind adc_control adc_control_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .conv_valid(conv_valid), .conv_raw(conv_raw), .converter_run(converter_run),
  .twelve_bit_mode(twelve_bit_mode), .dma_order_mode(dma_order_mode), .result_word(result_word),
  .result_valid(result_valid));
`default_nettype wire
